// ==== verilog/wts_pkg.sv ====
// package of constants and types for the withstand test sequencer
// Summary of operation
// - remote_select low hands start control from panel to remote inputs and enables the remote stop.
// - under remote control a low remote start begins a test.
// - a low remote stop ends a running test and removes output.
// - open remote inputs read as high, the inactive level.
// - maintained contact: make enters test, break stops it.
// - open safety loop forces protection, output off, testing refused.
// - stop does not release protection while the loop stays open.
// - protection from the loop clears on stop after the loop recloses.
// - ready output asserted in the ready state.
// - high voltage output asserted while testing or charge remains.
// - standard mode: pass shown about 200 ms, then ready.
// - fail output holds until ready or protection is entered.
// - protection output follows state except connector change while stopped, clear mode off.
// - each status output is a make contact, closed when asserted.
// - four independent mode switches, any combination supported.
// - two-step start: start counts only within 0.5 s after a stop.
// - two-step start: ready output only for 0.5 s after a stop.
// - pass latch: pass held until a stop arrives.
// - standard: test persists after start release until timer or stop.
// - hold-to-run: releasing start ends the test at once.
// - panel-only clear: remote stop ends test, clears pass, not fail/protection.
// - remote control disables panel start; both stops still stop a test.
// - timer expiry gives pass; leakage out of limits gives fail.
package wts_pkg;
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned MIN_WIDTH_MS      = 20;
    localparam int unsigned PASS_SHOW_MS      = 200;
    localparam int unsigned STEP_WINDOW_MS    = 500;
    localparam int unsigned MIN_WIDTH_CYC     = CLK_HZ / 1000 * MIN_WIDTH_MS;
    localparam int unsigned PASS_SHOW_CYC     = CLK_HZ / 1000 * PASS_SHOW_MS;
    localparam int unsigned STEP_WINDOW_CYC   = CLK_HZ / 1000 * STEP_WINDOW_MS;
    localparam logic [2:0]  CTRL_RESET        = 3'h0;
    localparam logic [31:0] TIMER_RESET       = 32'h0;
    // status register bit positions
    localparam int unsigned ST_READY_BIT      = 0;
    localparam int unsigned ST_TEST_BIT       = 1;
    localparam int unsigned ST_PASS_BIT       = 2;
    localparam int unsigned ST_FAIL_BIT       = 3;
    localparam int unsigned ST_PROT_BIT       = 4;
    localparam int unsigned ST_HV_BIT         = 5;
    localparam int unsigned ST_REMOTE_BIT     = 6;
    localparam int unsigned ST_LOOP_BIT       = 7;
    // control register bit positions
    localparam int unsigned CT_START_BIT      = 0;
    localparam int unsigned CT_STOP_BIT       = 1;
    localparam int unsigned CT_JUDGE_BIT      = 2;
    // apb byte addresses
    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;
    localparam logic [7:0]  ADDR_MODE         = 8'h08;
    typedef enum logic [2:0] {
        WTS_READY = 3'b000,
        WTS_TEST  = 3'b001,
        WTS_PASS  = 3'b010,
        WTS_FAIL  = 3'b011,
        WTS_PROT  = 3'b100
    } wts_state_t;
endpackage

// ==== verilog/wts_debounce.sv ====
// synchroniser and stability filter for one pin level
`timescale 1ns/1ns
`default_nettype none
module wts_debounce
    import wts_pkg::*;
#(
    parameter int unsigned STABLE_CYC = MIN_WIDTH_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      level_out
);
    localparam int unsigned CW = $clog2(STABLE_CYC + 1);
    logic          sync1_reg;
    logic          sync2_reg;
    logic [CW-1:0] cnt_reg;

    // idle level is high, same as an open pulled-up input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= '0;
            level_out <= 1'b1;
        end else if (sync2_reg == level_out) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= CW'(STABLE_CYC - 1)) begin
            cnt_reg   <= '0;
            level_out <= sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/wts_countdown.sv ====
// loadable down counter that reports when it is running
`timescale 1ns/1ns
`default_nettype none
module wts_countdown #(
    parameter int unsigned LOAD_CYC = 1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic load,
    input  wire logic clear,
    output logic      running,
    output logic      done
);
    localparam int unsigned CW = $clog2(LOAD_CYC + 1);
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (clear) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= CW'(LOAD_CYC);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign running = (cnt_reg != '0);
    assign done    = (cnt_reg == CW'(1));
endmodule
`default_nettype wire

// ==== verilog/wts_sequencer.sv ====
// withstand test sequencer: remote pins, safety loop, modes, status contacts, apb access
`timescale 1ns/1ns
`default_nettype none
module wts_sequencer
    import wts_pkg::*;
#(
    parameter int unsigned MIN_WIDTH  = MIN_WIDTH_CYC,
    parameter int unsigned PASS_SHOW  = PASS_SHOW_CYC,
    parameter int unsigned STEP_WIN   = STEP_WINDOW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        remote_select_n,
    input  wire logic        remote_start_n,
    input  wire logic        remote_stop_n,
    input  wire logic        safety_loop_closed,
    input  wire logic        panel_start,
    input  wire logic        panel_stop,
    input  wire logic [3:0]  mode_switch,
    input  wire logic        timer_expired,
    input  wire logic        leakage_fault,
    input  wire logic        residual_voltage,
    output logic             hv_enable,
    output logic             ready_contact,
    output logic             high_voltage_on_contact,
    output logic             pass_contact,
    output logic             fail_contact,
    output logic             protection_contact
);
    wts_state_t state_reg;
    wts_state_t state_next;

    logic sel_lvl;
    logic start_lvl;
    logic stop_lvl;
    logic loop_lvl;
    logic loop_closed_lvl;
    logic panel_start_s1_reg;
    logic panel_start_s2_reg;
    logic panel_stop_s1_reg;
    logic panel_stop_s2_reg;
    logic [3:0] mode_s1_reg;
    logic [3:0] mode_s2_reg;
    logic timer_s1_reg;
    logic timer_s2_reg;
    logic leak_s1_reg;
    logic leak_s2_reg;
    logic resid_s1_reg;
    logic resid_s2_reg;

    logic remote_mode;
    logic remote_start_reg;
    logic remote_stop_reg;
    logic panel_start_prev_reg;
    logic panel_stop_prev_reg;
    logic remote_mode_prev_reg;
    logic quiet_prot_reg;
    logic loop_tripped_reg;

    logic [2:0] sw_ctrl_reg;
    logic [2:0] sw_ctrl_prev_reg;

    logic start_held;
    logic start_edge;
    logic panel_stop_edge;
    logic remote_stop_edge;
    logic any_stop_edge;
    logic clearing_stop;
    logic step_open;
    logic pass_done;
    logic pass_load;
    logic two_step_start_mode;
    logic pass_latch_mode;
    logic hold_to_run_mode;
    logic panel_only_clear_mode;
    logic remote_changed;
    logic apb_write;
    logic sw_start;
    logic sw_stop;
    logic sw_judge;

    // remote pins and the safety loop are filtered to the minimum input width
    wts_debounce #(.STABLE_CYC(MIN_WIDTH)) u_db_sel   (.pclk(pclk), .presetn(presetn),
        .pin_in(remote_select_n), .level_out(sel_lvl));
    wts_debounce #(.STABLE_CYC(MIN_WIDTH)) u_db_start (.pclk(pclk), .presetn(presetn),
        .pin_in(remote_start_n), .level_out(start_lvl));
    wts_debounce #(.STABLE_CYC(MIN_WIDTH)) u_db_stop  (.pclk(pclk), .presetn(presetn),
        .pin_in(remote_stop_n), .level_out(stop_lvl));
    wts_debounce #(.STABLE_CYC(MIN_WIDTH)) u_db_loop  (.pclk(pclk), .presetn(presetn),
        .pin_in(safety_loop_closed), .level_out(loop_closed_lvl));
    // filter idles closed, so leaving reset does not look like an opened loop
    assign loop_lvl = ~loop_closed_lvl;

    // panel, switch and analog-side inputs only need two stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_start_s1_reg <= 1'b0;
            panel_start_s2_reg <= 1'b0;
            panel_stop_s1_reg  <= 1'b0;
            panel_stop_s2_reg  <= 1'b0;
            mode_s1_reg        <= 4'h0;
            mode_s2_reg        <= 4'h0;
            timer_s1_reg       <= 1'b0;
            timer_s2_reg       <= 1'b0;
            leak_s1_reg        <= 1'b0;
            leak_s2_reg        <= 1'b0;
            resid_s1_reg       <= 1'b0;
            resid_s2_reg       <= 1'b0;
        end else begin
            panel_start_s1_reg <= panel_start;
            panel_start_s2_reg <= panel_start_s1_reg;
            panel_stop_s1_reg  <= panel_stop;
            panel_stop_s2_reg  <= panel_stop_s1_reg;
            mode_s1_reg        <= mode_switch;
            mode_s2_reg        <= mode_s1_reg;
            timer_s1_reg       <= timer_expired;
            timer_s2_reg       <= timer_s1_reg;
            leak_s1_reg        <= leakage_fault;
            leak_s2_reg        <= leak_s1_reg;
            resid_s1_reg       <= residual_voltage;
            resid_s2_reg       <= resid_s1_reg;
        end
    end

    assign two_step_start_mode   = mode_s2_reg[0];
    assign pass_latch_mode       = mode_s2_reg[1];
    assign hold_to_run_mode      = mode_s2_reg[2];
    assign panel_only_clear_mode = mode_s2_reg[3];

    assign remote_mode = ~sel_lvl;

    // software command strobes, one pulse per written bit
    assign apb_write = psel & penable & pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_ctrl_reg      <= CTRL_RESET;
            sw_ctrl_prev_reg <= CTRL_RESET;
        end else begin
            sw_ctrl_prev_reg <= sw_ctrl_reg;
            if (apb_write && paddr == ADDR_CTRL) begin
                sw_ctrl_reg <= pwdata[2:0];
            end else begin
                sw_ctrl_reg <= CTRL_RESET;
            end
        end
    end
    assign sw_start = sw_ctrl_reg[CT_START_BIT] & ~sw_ctrl_prev_reg[CT_START_BIT];
    assign sw_stop  = sw_ctrl_reg[CT_STOP_BIT];
    assign sw_judge = sw_ctrl_reg[CT_JUDGE_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_start_reg     <= 1'b0;
            remote_stop_reg      <= 1'b0;
            panel_start_prev_reg <= 1'b0;
            panel_stop_prev_reg  <= 1'b0;
            remote_mode_prev_reg <= 1'b0;
        end else begin
            remote_start_reg     <= remote_mode & ~start_lvl;
            remote_stop_reg      <= remote_mode & ~stop_lvl;
            panel_start_prev_reg <= panel_start_s2_reg;
            panel_stop_prev_reg  <= panel_stop_s2_reg;
            remote_mode_prev_reg <= remote_mode;
        end
    end

    // panel start counts only under panel control
    assign start_held = remote_mode ? (remote_mode & ~start_lvl) : panel_start_s2_reg;
    assign start_edge = remote_mode ? ((remote_mode & ~start_lvl) & ~remote_start_reg)
                                    : ((panel_start_s2_reg & ~panel_start_prev_reg) | sw_start);
    assign panel_stop_edge  = (panel_stop_s2_reg & ~panel_stop_prev_reg) | sw_stop;
    assign remote_stop_edge = (remote_mode & ~stop_lvl) & ~remote_stop_reg;
    assign any_stop_edge    = panel_stop_edge | remote_stop_edge;
    // fail and protection may be cleared only by a panel or software stop in that mode
    assign clearing_stop    = panel_stop_edge | (remote_stop_edge & ~panel_only_clear_mode);
    assign remote_changed   = remote_mode ^ remote_mode_prev_reg;
    assign pass_load        = (state_reg == WTS_TEST) && (state_next == WTS_PASS);

    wts_countdown #(.LOAD_CYC(STEP_WIN)) u_step (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (any_stop_edge),
        .clear   (1'b0),
        .running (step_open),
        .done    ()
    );

    wts_countdown #(.LOAD_CYC(PASS_SHOW)) u_pass (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (pass_load),
        .clear   (state_reg != WTS_PASS && !pass_load),
        .running (),
        .done    (pass_done)
    );

    // protection from the loop latches until a clearing stop arrives in protection after the loop is closed again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_tripped_reg <= 1'b0;
        end else if (loop_lvl) begin
            loop_tripped_reg <= 1'b1;
        end else if (state_reg == WTS_PROT && clearing_stop) begin
            loop_tripped_reg <= 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            WTS_READY: begin
                if (start_edge && (!two_step_start_mode || step_open)) begin
                    state_next = WTS_TEST;
                end
            end
            WTS_TEST: begin
                if (any_stop_edge) begin
                    state_next = WTS_READY;
                end else if (hold_to_run_mode && !start_held) begin
                    state_next = WTS_READY;
                end else if (leak_s2_reg) begin
                    state_next = WTS_FAIL;
                end else if (timer_s2_reg || sw_judge) begin
                    state_next = WTS_PASS;
                end
            end
            WTS_PASS: begin
                if (any_stop_edge) begin
                    state_next = WTS_READY;
                end else if (!pass_latch_mode && pass_done) begin
                    state_next = WTS_READY;
                end
            end
            WTS_FAIL: begin
                if (clearing_stop) begin
                    state_next = WTS_READY;
                end
            end
            WTS_PROT: begin
                if (clearing_stop && !loop_lvl) begin
                    state_next = WTS_READY;
                end
            end
            default: state_next = WTS_PROT;
        endcase
        if (loop_lvl) begin
            state_next = WTS_PROT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WTS_READY;
        end else begin
            state_reg <= state_next;
        end
    end

    // with panel-only clear off, a connector change while stopped keeps the protection contact open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_prot_reg <= 1'b0;
        end else if (state_next != WTS_PROT) begin
            quiet_prot_reg <= 1'b0;
        end else if (state_reg != WTS_TEST && remote_changed && !panel_only_clear_mode) begin
            quiet_prot_reg <= 1'b1;
        end
    end

    // contacts follow the next state so they switch together with the state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_enable               <= 1'b0;
            ready_contact           <= 1'b0;
            high_voltage_on_contact <= 1'b0;
            pass_contact            <= 1'b0;
            fail_contact            <= 1'b0;
            protection_contact      <= 1'b0;
        end else begin
            hv_enable               <= (state_next == WTS_TEST);
            ready_contact           <= (state_next == WTS_READY)
                                       && (!two_step_start_mode || step_open);
            high_voltage_on_contact <= (state_next == WTS_TEST) || resid_s2_reg;
            pass_contact            <= (state_next == WTS_PASS);
            fail_contact            <= (state_next == WTS_FAIL);
            protection_contact      <= (state_next == WTS_PROT) && !quiet_prot_reg
                                       && !(state_reg != WTS_TEST && remote_changed
                                            && !panel_only_clear_mode);
        end
    end

    // apb read side, zero wait states
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_MODE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= TIMER_RESET;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0;
            unique case (paddr)
                ADDR_STATUS: begin
                    prdata[ST_READY_BIT]  <= (state_reg == WTS_READY);
                    prdata[ST_TEST_BIT]   <= (state_reg == WTS_TEST);
                    prdata[ST_PASS_BIT]   <= (state_reg == WTS_PASS);
                    prdata[ST_FAIL_BIT]   <= (state_reg == WTS_FAIL);
                    prdata[ST_PROT_BIT]   <= (state_reg == WTS_PROT);
                    prdata[ST_HV_BIT]     <= high_voltage_on_contact;
                    prdata[ST_REMOTE_BIT] <= remote_mode;
                    prdata[ST_LOOP_BIT]   <= loop_tripped_reg;
                end
                ADDR_MODE: prdata[3:0] <= mode_s2_reg;
                default:   prdata <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== test/wts_sequencer_assertions.sv ====
// checker for the sequencer contacts and high voltage enable
`timescale 1ns/1ns
`default_nettype none
module wts_sequencer_assertions
    import wts_pkg::*;
#(
    parameter int unsigned MIN_WIDTH = MIN_WIDTH_CYC,
    parameter int unsigned PASS_SHOW = PASS_SHOW_CYC,
    parameter int unsigned STEP_WIN  = STEP_WINDOW_CYC
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       safety_loop_closed,
    input wire logic [3:0] mode_switch,
    input wire logic       hv_enable,
    input wire logic       ready_contact,
    input wire logic       high_voltage_on_contact,
    input wire logic       pass_contact,
    input wire logic       fail_contact,
    input wire logic       protection_contact
);
    int unsigned loop_cnt_reg;
    int unsigned pass_cnt_reg;
    int unsigned rdy_cnt_reg;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // lengths of open loop, standard pass display and two-step ready display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_cnt_reg <= 0;
            pass_cnt_reg <= 0;
            rdy_cnt_reg  <= 0;
        end else begin
            loop_cnt_reg <= safety_loop_closed ? 0 : loop_cnt_reg + 1;
            pass_cnt_reg <= (pass_contact && !mode_switch[1]) ? pass_cnt_reg + 1 : 0;
            rdy_cnt_reg  <= (ready_contact && mode_switch[0]) ? rdy_cnt_reg + 1 : 0;
        end
    end
    a_loop_forces_prot: assert property (loop_cnt_reg > MIN_WIDTH + 8 |-> protection_contact && !hv_enable)
        else $error("open loop did not force protection");
    a_prot_no_hv: assert property (protection_contact |-> !hv_enable)
        else $error("output on during protection");
    a_pass_show_len: assert property (pass_cnt_reg <= PASS_SHOW + 6)
        else $error("pass shown too long");
    a_ready_window: assert property (rdy_cnt_reg <= STEP_WIN + 6)
        else $error("ready shown too long in two-step mode");
    a_result_exclusive: assert property (!(pass_contact && fail_contact))
        else $error("pass and fail together");
    a_fail_not_ready: assert property (fail_contact |-> !ready_contact)
        else $error("fail and ready together");
    a_hv_contact_on: assert property ($rose(hv_enable) |-> ##[0:2] high_voltage_on_contact)
        else $error("high voltage contact missing in test");
    a_test_not_ready: assert property ($rose(hv_enable) |-> ##[1:3] !ready_contact)
        else $error("ready stays on in test");
endmodule
bind wts_sequencer wts_sequencer_assertions #(.MIN_WIDTH(MIN_WIDTH), .PASS_SHOW(PASS_SHOW), .STEP_WIN(STEP_WIN)) chk (
    .pclk(pclk), .presetn(presetn), .safety_loop_closed(safety_loop_closed), .mode_switch(mode_switch),
    .hv_enable(hv_enable), .ready_contact(ready_contact), .high_voltage_on_contact(high_voltage_on_contact),
    .pass_contact(pass_contact), .fail_contact(fail_contact), .protection_contact(protection_contact));
`default_nettype wire

// ==== test/wts_remote_model.sv ====
// remote control device pulling the active-low connector pins
`timescale 1ns/1ns
`default_nettype none
module wts_remote_model #(
    parameter int HOLD = 12
) (
    input  wire logic pclk,
    output wire logic sel_n,
    output wire logic start_n,
    output wire logic stop_n
);
    logic [2:0] drv = 3'h0;
    // a released pin floats, the pull-up on the net makes it high
    assign sel_n   = drv[0] ? 1'b0 : 1'bz;
    assign start_n = drv[1] ? 1'b0 : 1'bz;
    assign stop_n  = drv[2] ? 1'b0 : 1'bz;
    task automatic hold(input int pin, input bit on);
        @(posedge pclk);
        drv[pin] <= on;
    endtask
    task automatic pulse(input int pin);
        hold(pin, 1'b1);
        repeat (HOLD) @(posedge pclk);
        hold(pin, 1'b0);
    endtask
    // changeover contact: make pulls start, break pulls stop
    task automatic maintained(input bit make);
        @(posedge pclk);
        drv[1] <= make;
        drv[2] <= !make;
    endtask
    task automatic clear_fail(input int wait_cyc);
        repeat (wait_cyc) @(posedge pclk);
        pulse(2);
    endtask
endmodule
`default_nettype wire

// ==== test/wts_sequencer_tb.sv ====
// self-checking bench for the withstand test sequencer
`timescale 1ns/1ns
`default_nettype none
module wts_sequencer_tb;
    import wts_pkg::*;
    localparam int MW = 4;
    localparam logic [4:0] RDY = 5'h10, TST = 5'h08, PAS = 5'h04, FAL = 5'h02, PRT = 5'h01;
    logic        pclk;
    logic        presetn, psel, penable, pwrite, e;
    logic        loop_ok, panel_start, panel_stop, tmr, leak, resid;
    logic [3:0]  modes;
    logic [7:0]  paddr;
    logic [31:0] pwdata, q;
    wire  [31:0] prdata;
    wire         pready, pslverr, hv_enable;
    wire  [4:0]  cts;
    tri1         rsel_n, rstart_n, rstop_n;
    int          err_count, total_checks;
    wts_sequencer #(.MIN_WIDTH(MW), .PASS_SHOW(20), .STEP_WIN(30)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .remote_select_n(rsel_n), .remote_start_n(rstart_n), .remote_stop_n(rstop_n),
        .safety_loop_closed(loop_ok), .panel_start(panel_start), .panel_stop(panel_stop),
        .mode_switch(modes), .timer_expired(tmr), .leakage_fault(leak), .residual_voltage(resid),
        .hv_enable(hv_enable), .ready_contact(cts[4]), .high_voltage_on_contact(cts[3]),
        .pass_contact(cts[2]), .fail_contact(cts[1]), .protection_contact(cts[0]));
    wts_remote_model #(.HOLD(3 * MW)) rm (.pclk(pclk), .sel_n(rsel_n), .start_n(rstart_n), .stop_n(rstop_n));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait for the contacts to settle, bounded
    task automatic expect_st(input logic [4:0] exp);
        int n = 0;
        while (cts !== exp && n < 200) begin
            @(posedge pclk);
            n++;
        end
        check({27'h0, cts}, {27'h0, exp});
    endtask
    task automatic stay(input int n, input logic [4:0] exp);
        repeat (n) @(posedge pclk);
        check({27'h0, cts}, {27'h0, exp});
    endtask
    task automatic press(input bit stp);
        @(posedge pclk);
        if (stp) panel_stop <= 1'b1;
        else panel_start <= 1'b1;
        repeat (4) @(posedge pclk);
        panel_stop  <= 1'b0;
        panel_start <= 1'b0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, panel_start, panel_stop, tmr, leak, resid} = 9'h0;
        {paddr, pwdata, modes, loop_ok, err_count, total_checks} = '0;
        loop_ok = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        expect_st(RDY);
        modes <= 4'hf;
        stay(4, 5'h00);
        apb(0, ADDR_MODE, 0);
        check(q, 32'hf);
        modes <= 4'h0;
        apb(0, 8'h0c, 0);
        check(e, 1);
        apb(0, ADDR_CTRL, 0);
        check(q, 0);
        expect_st(RDY);
        apb(1, ADDR_CTRL, 32'h1);
        expect_st(TST);
        check(hv_enable, 1);
        apb(0, ADDR_STATUS, 0);
        check(q, 32'h22);
        stay(40, TST);
        tmr <= 1'b1;
        expect_st(PAS);
        tmr <= 1'b0;
        expect_st(RDY);
        press(0);
        expect_st(TST);
        leak <= 1'b1;
        expect_st(FAL);
        leak <= 1'b0;
        stay(40, FAL);
        press(1);
        expect_st(RDY);
        rm.hold(0, 1'b1);
        stay(20, RDY);
        press(0);
        stay(20, RDY);
        rm.pulse(1);
        expect_st(TST);
        press(1);
        expect_st(RDY);
        rm.pulse(1);
        expect_st(TST);
        rm.pulse(2);
        expect_st(RDY);
        rm.maintained(1'b1);
        expect_st(TST);
        rm.maintained(1'b0);
        expect_st(RDY);
        rm.hold(2, 1'b0);
        rm.pulse(1);
        expect_st(TST);
        leak <= 1'b1;
        expect_st(FAL);
        leak <= 1'b0;
        rm.clear_fail(5 * MW);
        expect_st(RDY);
        modes <= 4'h8;
        rm.pulse(1);
        expect_st(TST);
        rm.pulse(2);
        expect_st(RDY);
        rm.pulse(1);
        expect_st(TST);
        leak <= 1'b1;
        expect_st(FAL);
        leak <= 1'b0;
        rm.clear_fail(5 * MW);
        stay(20, FAL);
        press(1);
        expect_st(RDY);
        modes <= 4'h0;
        rm.hold(0, 1'b0);
        stay(20, RDY);
        press(0);
        expect_st(TST);
        loop_ok <= 1'b0;
        expect_st(PRT);
        check(hv_enable, 0);
        press(1);
        stay(20, PRT);
        press(0);
        stay(20, PRT);
        loop_ok <= 1'b1;
        stay(20, PRT);
        rm.hold(0, 1'b1);
        expect_st(5'h00);
        rm.hold(0, 1'b0);
        press(1);
        expect_st(RDY);
        modes <= 4'h2;
        press(0);
        expect_st(TST);
        tmr <= 1'b1;
        expect_st(PAS);
        tmr <= 1'b0;
        stay(60, PAS);
        apb(1, ADDR_CTRL, 32'h2);
        expect_st(RDY);
        modes <= 4'h4;
        panel_start <= 1'b1;
        expect_st(TST);
        resid <= 1'b1;
        panel_start <= 1'b0;
        expect_st(5'h18);
        check(hv_enable, 0);
        resid <= 1'b0;
        expect_st(RDY);
        modes <= 4'h1;
        stay(45, 5'h00);
        press(0);
        stay(20, 5'h00);
        press(1);
        press(0);
        expect_st(TST);
        press(1);
        expect_st(RDY);
        stay(45, 5'h00);
        modes <= 4'h0;
        stop_test();
    end
endmodule
`default_nettype wire
